// *** hdl/trace_id_defines.vh ***
// trace_id_defines.vh: offsets, field positions and widths of the
// factory traceability register bank.
// assumes: included by bare name from the design files under hdl/.
`ifndef TRACE_ID_DEFINES_VH
`define TRACE_ID_DEFINES_VH

// ************************************************************
// register offsets
// ************************************************************
`define OFS_SERIAL_BYTE0 8'hc6
`define OFS_SERIAL_BYTE1 8'hc7
`define OFS_SERIAL_BYTE2 8'hc8
`define OFS_SERIAL_BYTE3 8'hc9
`define OFS_SERIAL_BYTE4 8'hca
`define OFS_LOGIC_WAFER_NUM 8'hcb
`define OFS_LOGIC_WAFER_X 8'hcc
`define OFS_LOGIC_WAFER_Y 8'hcd
`define OFS_DEVICE_REVISION 8'hce
`define OFS_LOGIC_LOT_LOW 8'hd0
`define OFS_LOGIC_LOT_HIGH 8'hd1
`define OFS_SENSE_WAFER_X 8'hd2
`define OFS_SENSE_WAFER_Y 8'hd3
`define OFS_SENSE_LOT_LOW 8'hd4
`define OFS_SENSE_LOT_HIGH 8'hd5
`define OFS_SENSE_WAFER_REV 8'hda

// ************************************************************
// field layout
// ************************************************************
`define SERIAL_WIDTH 40
`define SERIAL_IN_LOT_LSB 0
`define SERIAL_IN_LOT_WIDTH 16
`define LOT_NUMBER_LSB 16
`define LOT_NUMBER_WIDTH 20
`define TEST_ID_LSB 36
`define TEST_ID_WIDTH 4
`define SENSE_WAFER_FIELD_WIDTH 5
`define ASSEMBLY_REV_LSB 5
`define ASSEMBLY_REV_WIDTH 3
`define DEVICE_REV_WIDTH 4
`define DEVICE_REV_PRODUCTION 4'hf

// ************************************************************
// image and reset values
// ************************************************************
`define IMAGE_BYTES 16
`define IMAGE_WIDTH 128
`define READ_DATA_RESET 8'h00
`define CHECK_WIDTH 8

`endif

// *** hdl/trace_id_decode.v ***
// trace_id_decode.v: maps a register address onto an image byte slot.
// assumes: address is stable for the cycle; purely combinational.
`timescale 1ns/1ps
`default_nettype none
`include "trace_id_defines.vh"

module trace_id_decode (
    // address in
    input wire [7:0] addr,
    // slot out
    output reg [3:0] slot,
    output reg hit
);

    always @* begin
        hit = 1'b1;
        slot = 4'h0;
        case (addr)
            `OFS_SERIAL_BYTE0: slot = 4'h0;
            `OFS_SERIAL_BYTE1: slot = 4'h1;
            `OFS_SERIAL_BYTE2: slot = 4'h2;
            `OFS_SERIAL_BYTE3: slot = 4'h3;
            `OFS_SERIAL_BYTE4: slot = 4'h4;
            `OFS_LOGIC_WAFER_NUM: slot = 4'h5;
            `OFS_LOGIC_WAFER_X: slot = 4'h6;
            `OFS_LOGIC_WAFER_Y: slot = 4'h7;
            `OFS_DEVICE_REVISION: slot = 4'h8;
            `OFS_LOGIC_LOT_LOW: slot = 4'h9;
            `OFS_LOGIC_LOT_HIGH: slot = 4'ha;
            `OFS_SENSE_WAFER_X: slot = 4'hb;
            `OFS_SENSE_WAFER_Y: slot = 4'hc;
            `OFS_SENSE_LOT_LOW: slot = 4'hd;
            `OFS_SENSE_LOT_HIGH: slot = 4'he;
            `OFS_SENSE_WAFER_REV: slot = 4'hf;
            default: hit = 1'b0;
        endcase
    end

endmodule
`default_nettype wire

// *** hdl/trace_id_check.v ***
// trace_id_check.v: xor-rotate check word over the factory image.
// assumes: image is static after load; the result is compared against
// the stored check word by the caller.
`timescale 1ns/1ps
`default_nettype none
`include "trace_id_defines.vh"

module trace_id_check #(
    parameter BYTES = `IMAGE_BYTES
) (
    // image in
    input wire [8*BYTES-1:0] image,
    // check word out
    output wire [`CHECK_WIDTH-1:0] check
);

    // each byte is rotated by its index mod 8; swapped bytes go undetected if they lie 8 slots apart or their xor is unchanged by that rotation difference
    wire [`CHECK_WIDTH-1:0] acc [0:BYTES];
    assign acc[0] = 8'h00;

    genvar i;
    generate
        for (i = 0; i < BYTES; i = i + 1) begin : g_byte
            wire [7:0] b = image[8*i +: 8];
            wire [15:0] dbl = {b, b};
            wire [7:0] rot = dbl[(i % 8) +: 8];
            assign acc[i+1] = acc[i] ^ rot;
        end
    endgenerate

    assign check = acc[BYTES];

endmodule
`default_nettype wire

// *** hdl/trace_id_regs.v ***
// trace_id_regs.v: factory traceability register bank, read-only.
// assumes: the interface front end presents a one-cycle read or write
// strobe with an 8-bit address; the otp image and its check word are
// static factory values on plain inputs.
`timescale 1ns/1ps
`default_nettype none
`include "trace_id_defines.vh"

module trace_id_regs (
    // clock and reset
    input wire CLK,
    input wire RESET,
    // mode and init state
    input wire HOST_MODE_ACTIVE,
    input wire INIT_DONE_FLAG,
    // register access from the interface front end
    input wire RD_STROBE,
    input wire WR_STROBE,
    input wire [7:0] ADDR,
    input wire [7:0] WR_DATA,
    output reg [7:0] RD_DATA,
    output reg RD_VALID,
    output reg RD_ERROR,
    // factory otp content
    input wire [`SERIAL_WIDTH-1:0] UNIT_SERIAL_VALUE,
    input wire [7:0] LOGIC_DIE_WAFER_FIELD,
    input wire [7:0] LOGIC_DIE_WAFER_X,
    input wire [7:0] LOGIC_DIE_WAFER_Y,
    input wire [15:0] LOGIC_DIE_LOT,
    input wire [7:0] SENSE_DIE_WAFER_X,
    input wire [7:0] SENSE_DIE_WAFER_Y,
    input wire [15:0] SENSE_DIE_LOT,
    input wire [`SENSE_WAFER_FIELD_WIDTH-1:0] SENSE_DIE_WAFER_FIELD,
    input wire [`ASSEMBLY_REV_WIDTH-1:0] ASSEMBLY_REV_COUNTER,
    input wire [`DEVICE_REV_WIDTH-1:0] DEVICE_REVISION_NIBBLE,
    input wire [`CHECK_WIDTH-1:0] STORED_CHECK,
    // decoded views and status
    output reg [`SERIAL_IN_LOT_WIDTH-1:0] SERIAL_IN_LOT,
    output reg [`LOT_NUMBER_WIDTH-1:0] LOT_NUMBER,
    output reg [`TEST_ID_WIDTH-1:0] TEST_ID,
    output reg IDENT_UNASSIGNED,
    output reg PRODUCTION_DEVICE,
    output reg OTP_CHECK_FAIL
);

    // ************************************************************
    // image assembly
    // ************************************************************
    wire [`IMAGE_WIDTH-1:0] image;
    wire [7:0] sense_wafer_byte;
    wire [7:0] revision_byte;

    // reserved upper nibble forced to zero, not taken from otp
    assign revision_byte = {4'h0, DEVICE_REVISION_NIBBLE};
    assign sense_wafer_byte = {ASSEMBLY_REV_COUNTER,
                               SENSE_DIE_WAFER_FIELD};

    assign image = {
        sense_wafer_byte,          // slot 15
        SENSE_DIE_LOT[15:8],       // slot 14
        SENSE_DIE_LOT[7:0],        // slot 13
        SENSE_DIE_WAFER_Y,         // slot 12
        SENSE_DIE_WAFER_X,         // slot 11
        LOGIC_DIE_LOT[15:8],       // slot 10
        LOGIC_DIE_LOT[7:0],        // slot 9
        revision_byte,             // slot 8
        LOGIC_DIE_WAFER_Y,         // slot 7
        LOGIC_DIE_WAFER_X,         // slot 6
        LOGIC_DIE_WAFER_FIELD,     // slot 5
        UNIT_SERIAL_VALUE          // slots 4..0, lsb byte first
    };

    // ************************************************************
    // address decode and check
    // ************************************************************
    wire [3:0] slot;
    wire hit;
    wire [`CHECK_WIDTH-1:0] check;

    trace_id_decode u_decode (
        .addr(ADDR),
        .slot(slot),
        .hit(hit)
    );

    trace_id_check #(
        .BYTES(`IMAGE_BYTES)
    ) u_check (
        .image(image),
        .check(check)
    );

    // ************************************************************
    // read path
    // ************************************************************
    // after init is done the bank goes dark; the host must read first
    wire read_allowed = HOST_MODE_ACTIVE & ~INIT_DONE_FLAG;
    wire [7:0] slot_byte = image[{slot, 3'b000} +: 8];

    reg [7:0] rd_data_d;
    reg rd_error_d;

    always @* begin
        rd_data_d = `READ_DATA_RESET;
        rd_error_d = 1'b0;
        if (RD_STROBE) begin
            if (read_allowed && hit) begin
                rd_data_d = slot_byte;
            end else begin
                rd_error_d = 1'b1;
            end
        end
    end

    // writes land nowhere: the bank has no storage a write can reach
    always @(posedge CLK) begin
        if (RESET) begin
            RD_DATA <= `READ_DATA_RESET;
            RD_VALID <= 1'b0;
            RD_ERROR <= 1'b0;
        end else begin
            RD_VALID <= RD_STROBE & ~WR_STROBE;
            RD_ERROR <= rd_error_d & ~WR_STROBE;
            if (RD_STROBE && !WR_STROBE) begin
                RD_DATA <= rd_data_d;
            end
        end
    end

    // ************************************************************
    // decoded views and status
    // ************************************************************
    wire [`SERIAL_IN_LOT_WIDTH-1:0] in_lot_w =
        UNIT_SERIAL_VALUE[`SERIAL_IN_LOT_LSB +: `SERIAL_IN_LOT_WIDTH];
    wire [`LOT_NUMBER_WIDTH-1:0] lot_w =
        UNIT_SERIAL_VALUE[`LOT_NUMBER_LSB +: `LOT_NUMBER_WIDTH];

    always @(posedge CLK) begin
        if (RESET) begin
            SERIAL_IN_LOT <= {`SERIAL_IN_LOT_WIDTH{1'b0}};
            LOT_NUMBER <= {`LOT_NUMBER_WIDTH{1'b0}};
            TEST_ID <= {`TEST_ID_WIDTH{1'b0}};
            IDENT_UNASSIGNED <= 1'b1;
            PRODUCTION_DEVICE <= 1'b0;
            OTP_CHECK_FAIL <= 1'b0;
        end else begin
            SERIAL_IN_LOT <= in_lot_w;
            LOT_NUMBER <= lot_w;
            TEST_ID <= UNIT_SERIAL_VALUE[`TEST_ID_LSB +: `TEST_ID_WIDTH];
            // zero is never issued for lot or in-lot serial
            IDENT_UNASSIGNED <= (in_lot_w == 16'h0000) ||
                                (lot_w == 20'h00000);
            PRODUCTION_DEVICE <=
                (DEVICE_REVISION_NIBBLE == `DEVICE_REV_PRODUCTION);
            OTP_CHECK_FAIL <= (check != STORED_CHECK);
        end
    end

endmodule
`default_nettype wire

// *** tb/trace_id_monitor.sv ***
// trace_id_monitor.sv: port assertions for the traceability bank.
// assumes: bound onto every trace_id_regs instance.
`timescale 1ns/1ps
`default_nettype none
// ****
// checker
// ****
module trace_id_monitor (
    // clock and reset
    input wire CLK,
    input wire RESET,
    // access
    input wire HOST_MODE_ACTIVE,
    input wire INIT_DONE_FLAG,
    input wire RD_STROBE,
    input wire WR_STROBE,
    input wire [7:0] ADDR,
    input wire [7:0] RD_DATA,
    input wire RD_VALID,
    input wire RD_ERROR,
    // otp and status
    input wire [39:0] UNIT_SERIAL_VALUE,
    input wire [4:0] SENSE_DIE_WAFER_FIELD,
    input wire [2:0] ASSEMBLY_REV_COUNTER,
    input wire [3:0] DEVICE_REVISION_NIBBLE,
    input wire PRODUCTION_DEVICE
);
    wire take = RD_STROBE && !WR_STROBE;
    wire ok = take && HOST_MODE_ACTIVE && !INIT_DONE_FLAG;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    chk_read_answered: assert property (take |=> RD_VALID)
        else $error("read not answered next cycle");
    // a write in the same cycle must swallow the read
    chk_quiet_otherwise: assert property (!take |=> !RD_VALID)
        else $error("answer without a read");
    chk_refused_read: assert property (take && (INIT_DONE_FLAG ||
        !HOST_MODE_ACTIVE) |=> RD_ERROR && RD_DATA == 8'h00)
        else $error("locked read not refused");
    chk_serial_low_byte: assert property (ok && ADDR == 8'hc6 |=>
        !RD_ERROR && RD_DATA == $past(UNIT_SERIAL_VALUE[7:0]))
        else $error("serial low byte wrong");
    chk_serial_top_byte: assert property (ok && ADDR == 8'hca |=>
        RD_DATA == $past(UNIT_SERIAL_VALUE[39:32]))
        else $error("serial top byte wrong");
    chk_revision_byte: assert property (ok && ADDR == 8'hce |=>
        RD_DATA == {4'h0, $past(DEVICE_REVISION_NIBBLE)})
        else $error("revision byte wrong");
    chk_sense_wafer_byte: assert property (ok && ADDR == 8'hda |=>
        RD_DATA == {$past(ASSEMBLY_REV_COUNTER), $past(SENSE_DIE_WAFER_FIELD)})
        else $error("sense wafer byte wrong");
    chk_production_flag: assert property (1'b1 |=>
        PRODUCTION_DEVICE == ($past(DEVICE_REVISION_NIBBLE) == 4'hf))
        else $error("production flag wrong");
endmodule
bind trace_id_regs trace_id_monitor mon (.CLK, .RESET, .HOST_MODE_ACTIVE,
    .INIT_DONE_FLAG, .RD_STROBE, .WR_STROBE, .ADDR, .RD_DATA, .RD_VALID,
    .RD_ERROR, .UNIT_SERIAL_VALUE, .SENSE_DIE_WAFER_FIELD,
    .ASSEMBLY_REV_COUNTER, .DEVICE_REVISION_NIBBLE, .PRODUCTION_DEVICE);
`default_nettype wire

// *** tb/host_model.sv ***
// host_model.sv: host side of the register path, strobes one access.
// assumes: tasks are entered 1 ns after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
// ****
// host
// ****
module host_model (
    // clock
    input wire CLK,
    // request
    output logic RD_STROBE,
    output logic WR_STROBE,
    output logic [7:0] ADDR,
    output logic [7:0] WR_DATA,
    // answer
    input wire [7:0] RD_DATA,
    input wire RD_VALID,
    input wire RD_ERROR
);
    int lost = 0;
    initial begin
        RD_STROBE = 0;
        WR_STROBE = 0;
        ADDR = 8'h00;
        WR_DATA = 8'h00;
    end
    // callers issue reads with the init-done flag low, except the refusal test that raises it
    task automatic rd(input [7:0] a, output [7:0] d, output e);
        int i;
        ADDR = a;
        RD_STROBE = 1;
        @(posedge CLK) #1;
        RD_STROBE = 0;
        for (i = 0; i < 4 && RD_VALID !== 1'b1; i++)
            @(posedge CLK) #1;
        if (i == 4)
            lost++;
        d = RD_DATA;
        e = RD_ERROR;
        // one idle edge, so a following call never reassigns the strobe
        // in the time step in which this one lowered it
        @(posedge CLK) #1;
    endtask
    task automatic wr(input [7:0] a, input [7:0] d);
        ADDR = a;
        WR_DATA = d;
        WR_STROBE = 1;
        @(posedge CLK) #1;
        WR_STROBE = 0;
        @(posedge CLK) #1;
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// testbench.sv: register reads, writes and refusals on the bank.
// assumes: trace_id_regs, host_model and the monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, x, g) begin compares++; if ((g) !== (x)) begin \
    n_errors++; $display("Error %s expected %h seen %h", n, x, g); end end
// ****
// bench
// ****
module testbench;
    logic clk = 0, reset = 1, mode = 1, init = 0;
    logic [39:0] serial = 40'h3001480150;
    logic [15:0] llot = 16'h9a0b, slot = 16'h1234;
    logic [3:0] rev = 4'hf;
    logic [4:0] swf = 5'h0d;
    logic [2:0] arc = 3'h5;
    logic [7:0] chk = 8'h00, d;
    logic [15:0] r;
    logic e;
    wire rs, ws, rv, re, unas, prod, ckf;
    wire [7:0] a, wd, rdat;
    wire [15:0] inlot;
    wire [19:0] lot;
    wire [3:0] tid;
    int n_errors = 0, compares = 0, i;
    // slot order is also the check word order
    logic [15:0] tab [16] = '{16'hc650, 16'hc701, 16'hc848, 16'hc901,
        16'hca30, 16'hcb17, 16'hcc21, 16'hcd2e, 16'hce0f, 16'hd00b,
        16'hd19a, 16'hd244, 16'hd355, 16'hd434, 16'hd512, 16'hdaad};
    always #25 clk = ~clk;
    host_model host (.CLK(clk), .RD_STROBE(rs), .WR_STROBE(ws), .ADDR(a),
        .WR_DATA(wd), .RD_DATA(rdat), .RD_VALID(rv), .RD_ERROR(re));
    trace_id_regs uut (.CLK(clk), .RESET(reset), .HOST_MODE_ACTIVE(mode),
        .INIT_DONE_FLAG(init), .RD_STROBE(rs), .WR_STROBE(ws), .ADDR(a),
        .WR_DATA(wd), .RD_DATA(rdat), .RD_VALID(rv), .RD_ERROR(re),
        .UNIT_SERIAL_VALUE(serial), .LOGIC_DIE_WAFER_FIELD(8'h17),
        .LOGIC_DIE_WAFER_X(8'h21), .LOGIC_DIE_WAFER_Y(8'h2e),
        .LOGIC_DIE_LOT(llot), .SENSE_DIE_WAFER_X(8'h44),
        .SENSE_DIE_WAFER_Y(8'h55), .SENSE_DIE_LOT(slot),
        .SENSE_DIE_WAFER_FIELD(swf), .ASSEMBLY_REV_COUNTER(arc),
        .DEVICE_REVISION_NIBBLE(rev), .STORED_CHECK(chk),
        .SERIAL_IN_LOT(inlot), .LOT_NUMBER(lot), .TEST_ID(tid),
        .IDENT_UNASSIGNED(unas), .PRODUCTION_DEVICE(prod),
        .OTP_CHECK_FAIL(ckf));
    task automatic refuse(input [7:0] ad);
        host.rd(ad, d, e);
        `CHK("refused error", 1'b1, e)
        `CHK("refused data", 8'h00, d)
    endtask
    task automatic results;
        n_errors += host.lost;
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        for (i = 0; i < 16; i++) begin
            r = {tab[i][7:0], tab[i][7:0]} >> (i % 8);
            chk = chk ^ r[7:0];
        end
        repeat (8) @(posedge clk) #1;
        reset = 0;
        repeat (2) @(posedge clk) #1;
        `CHK("in-lot serial", 16'h0150, inlot)
        `CHK("lot number", 20'h00148, lot)
        `CHK("test id", 4'h3, tid)
        `CHK("unassigned", 1'b0, unas)
        `CHK("production", 1'b1, prod)
        `CHK("check fail", 1'b0, ckf)
        $display("decode test done");
        for (i = 0; i < 16; i++) begin
            host.rd(tab[i][15:8], d, e);
            `CHK("read data", tab[i][7:0], d)
            `CHK("read error", 1'b0, e)
        end
        $display("map test done");
        host.wr(8'hc6, 8'hff);
        host.wr(8'hce, 8'hf0);
        host.rd(8'hc6, d, e);
        `CHK("serial after write", 8'h50, d)
        host.rd(8'hce, d, e);
        `CHK("revision after write", 8'h0f, d)
        $display("write test done");
        refuse(8'hcf);
        mode = 0;
        refuse(8'hc6);
        mode = 1;
        init = 1;
        refuse(8'hda);
        init = 0;
        $display("refusal test done");
        rev = 4'h3;
        serial = 40'h3001480000;
        repeat (2) @(posedge clk) #1;
        `CHK("check fail", 1'b1, ckf)
        `CHK("production", 1'b0, prod)
        `CHK("unassigned", 1'b1, unas)
        host.rd(8'hce, d, e);
        `CHK("engineering revision", 8'h03, d)
        serial = 40'h3000000150;
        swf = 5'h1f;
        arc = 3'h2;
        repeat (2) @(posedge clk) #1;
        `CHK("unassigned lot", 1'b1, unas)
        `CHK("zero lot", 20'h00000, lot)
        host.rd(8'hda, d, e);
        `CHK("sense wafer byte", 8'h5f, d)
        $display("status test done");
        // a second reset in mid-run must clear read data, the check-fail flag and the in-lot serial
        reset = 1;
        @(posedge clk) #1;
        `CHK("reset data", 8'h00, rdat)
        `CHK("reset check fail", 1'b0, ckf)
        `CHK("reset in-lot serial", 16'h0000, inlot)
        reset = 0;
        repeat (2) @(posedge clk) #1;
        `CHK("check fail after reset", 1'b1, ckf)
        `CHK("in-lot after reset", 16'h0150, inlot)
        $display("reset test done");
        results();
    end
endmodule
`default_nettype wire
